/* File: rtl/pbc_pkg.sv */
// constants and types for the power budget capability register bank
package pbc_pkg;
  localparam int unsigned ADDR_W = 12;
  localparam logic [11:0] OFS_HEADER = 12'h280;
  localparam logic [11:0] OFS_SELECT = 12'h284;
  localparam logic [11:0] OFS_READOUT = 12'h288;
  localparam logic [11:0] OFS_FLAGS = 12'h28C;
  localparam logic [11:0] OFS_VALUE_BASE = 12'h300;
  localparam logic [11:0] OFS_CONTROL = 12'h3F0;
  localparam int unsigned NUM_VALUES = 8;
  localparam logic [7:0] SEL_MAX = 8'h07;
  localparam logic [15:0] IDENT_POWER_BUDGET = 16'h0004;
  localparam logic [3:0] VERSION_ONE = 4'h1;
  localparam logic [31:0] HEADER_RESET = 32'h0000_0000;
  localparam logic [7:0] SELECT_RESET = 8'h00;
  localparam logic [31:0] VALUE_RESET = 32'h0000_0000;
  localparam int unsigned CTL_VALUE_UNLOCK_BIT = 0;
  localparam int unsigned CTL_LOCKABLE_UNLOCK_BIT = 1;
  localparam int unsigned FLAG_SYS_ALLOC_BIT = 0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [11:0] next_capability_pointer;
    logic [3:0] capability_version;
    logic [15:0] capability_identifier;
  } pbc_header_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } pbc_wreq_t;
endpackage : pbc_pkg

/* File: rtl/pbc_regs.sv */
// power budget capability register bank behind an axi4-lite slave
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps

module pbc_regs #(
  parameter int unsigned ADDR_W = pbc_pkg::ADDR_W
) (
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic [ADDR_W-1:0] i_awaddr,
  input wire logic [2:0] i_awprot,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  input wire logic i_wvalid,
  output logic o_wready,
  output logic [1:0] o_bresp,
  output logic o_bvalid,
  input wire logic i_bready,
  input wire logic [ADDR_W-1:0] i_araddr,
  input wire logic [2:0] i_arprot,
  input wire logic i_arvalid,
  output logic o_arready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic o_system_allocated
);

  if (ADDR_W != 12)
  begin : g_bad_addr_w
    $error("pbc_regs: ADDR_W must be 12");
  end

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++)
    begin
      if (strb[b])
      begin
        r[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return r;
  endfunction : merge

  // write and read channel holding flops
  logic aw_full_q;
  logic w_full_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;

  // register state
  pbc_pkg::pbc_header_t header_q;
  logic [7:0] value_selector_q;
  logic system_allocated_flag_q;
  logic budget_value_unlock_q;
  logic lockable_unlock_q;
  logic [31:0] budget_value_register_q [pbc_pkg::NUM_VALUES];

  // handshakes
  wire aw_take = i_awvalid && o_awready;
  wire w_take = i_wvalid && o_wready;
  wire ar_take = i_arvalid && o_arready;
  wire wr_go = aw_full_q && w_full_q && !bvalid_q;
  assign o_awready = !aw_full_q;
  assign o_wready = !w_full_q;
  assign o_arready = !rvalid_q;
  assign o_bvalid = bvalid_q;
  assign o_bresp = bresp_q;
  assign o_rvalid = rvalid_q;
  assign o_rresp = rresp_q;
  assign o_rdata = rdata_q;
  assign o_system_allocated = system_allocated_flag_q;

  // write decode
  wire [9:0] wr_word = aw_addr_q[11:2];
  wire wr_hdr = wr_word == pbc_pkg::OFS_HEADER[11:2];
  wire wr_sel = wr_word == pbc_pkg::OFS_SELECT[11:2];
  wire wr_rdo = wr_word == pbc_pkg::OFS_READOUT[11:2];
  wire wr_flg = wr_word == pbc_pkg::OFS_FLAGS[11:2];
  wire wr_ctl = wr_word == pbc_pkg::OFS_CONTROL[11:2];
  wire wr_val = aw_addr_q[11:5] == pbc_pkg::OFS_VALUE_BASE[11:5];
  wire [2:0] wr_idx = aw_addr_q[4:2];
  wire wr_mapped = wr_hdr || wr_sel || wr_rdo || wr_flg || wr_ctl || wr_val;
  wire lock_ok = lockable_unlock_q;
  wire [31:0] wr_merge_hdr = merge(header_q, w_data_q, w_strb_q);
  wire [31:0] wr_merge_sel = merge({24'h000000, value_selector_q},
                                   w_data_q, w_strb_q);
  wire [31:0] wr_merge_flg = merge({31'h00000000, system_allocated_flag_q},
                                   w_data_q, w_strb_q);
  wire [31:0] wr_merge_ctl = merge({30'h00000000, lockable_unlock_q,
                                    budget_value_unlock_q},
                                   w_data_q, w_strb_q);

  // read decode
  wire [9:0] rd_word = i_araddr[11:2];
  wire rd_hdr = rd_word == pbc_pkg::OFS_HEADER[11:2];
  wire rd_sel = rd_word == pbc_pkg::OFS_SELECT[11:2];
  wire rd_rdo = rd_word == pbc_pkg::OFS_READOUT[11:2];
  wire rd_flg = rd_word == pbc_pkg::OFS_FLAGS[11:2];
  wire rd_ctl = rd_word == pbc_pkg::OFS_CONTROL[11:2];
  wire rd_val = i_araddr[11:5] == pbc_pkg::OFS_VALUE_BASE[11:5];
  wire rd_mapped = rd_hdr || rd_sel || rd_rdo || rd_flg || rd_ctl || rd_val;
  // selectors past the last value register read as zero
  wire sel_in_range = value_selector_q <= pbc_pkg::SEL_MAX;
  wire [31:0] readout = sel_in_range ?
    budget_value_register_q[value_selector_q[2:0]] : 32'h0000_0000;
  wire [31:0] rd_mux =
    rd_hdr ? header_q :
    rd_sel ? {24'h000000, value_selector_q} :
    rd_rdo ? readout :
    rd_flg ? {31'h00000000, system_allocated_flag_q} :
    rd_ctl ? {30'h00000000, lockable_unlock_q, budget_value_unlock_q} :
    rd_val ? budget_value_register_q[i_araddr[4:2]] : 32'h0000_0000;

  // axi write channel bookkeeping
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      aw_full_q <= 1'b0;
      w_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      bvalid_q <= 1'b0;
      bresp_q <= pbc_pkg::RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_full_q <= 1'b1;
        aw_addr_q <= i_awaddr;
      end
      else if (wr_go)
      begin
        aw_full_q <= 1'b0;
      end
      if (w_take)
      begin
        w_full_q <= 1'b1;
        w_data_q <= i_wdata;
        w_strb_q <= i_wstrb;
      end
      else if (wr_go)
      begin
        w_full_q <= 1'b0;
      end
      if (wr_go)
      begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? pbc_pkg::RESP_OKAY : pbc_pkg::RESP_SLVERR;
      end
      else if (i_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // axi read channel, answer one cycle after the address is taken
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      rvalid_q <= 1'b0;
      rresp_q <= pbc_pkg::RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_mapped ? pbc_pkg::RESP_OKAY : pbc_pkg::RESP_SLVERR;
      rdata_q <= rd_mux;
    end
    else if (i_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // capability header, flags and control; lockable fields need unlock
  always_ff @(posedge i_ref_clk)
  begin
    if (!i_nrst)
    begin
      header_q <= pbc_pkg::HEADER_RESET;
      value_selector_q <= pbc_pkg::SELECT_RESET;
      system_allocated_flag_q <= 1'b0;
      budget_value_unlock_q <= 1'b0;
      lockable_unlock_q <= 1'b0;
    end
    else if (wr_go)
    begin
      if (wr_hdr && lock_ok)
      begin
        header_q <= wr_merge_hdr;
      end
      if (wr_sel)
      begin
        value_selector_q <= wr_merge_sel[7:0];
      end
      if (wr_flg && lock_ok)
      begin
        system_allocated_flag_q <=
          wr_merge_flg[pbc_pkg::FLAG_SYS_ALLOC_BIT];
      end
      if (wr_ctl)
      begin
        budget_value_unlock_q <= wr_merge_ctl[pbc_pkg::CTL_VALUE_UNLOCK_BIT];
        lockable_unlock_q <= wr_merge_ctl[pbc_pkg::CTL_LOCKABLE_UNLOCK_BIT];
      end
    end
  end

  // value registers; a locked write is acknowledged but discarded
  for (genvar gi = 0; gi < pbc_pkg::NUM_VALUES; gi++)
  begin : g_value
    wire hit = wr_go && wr_val && (wr_idx == 3'(gi)) && budget_value_unlock_q;
    always_ff @(posedge i_ref_clk)
    begin
      if (!i_nrst)
      begin
        budget_value_register_q[gi] <= pbc_pkg::VALUE_RESET;
      end
      else if (hit)
      begin
        budget_value_register_q[gi] <= merge(budget_value_register_q[gi],
                                             w_data_q, w_strb_q);
      end
    end
  end

  // checks
  a_ident_after_reset: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    !$past(i_nrst) |-> header_q.capability_identifier == 16'h0000)
    else $error("identifier not zero after reset");

  a_version_held_locked: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    (wr_go && wr_hdr && !lock_ok) |=> $stable(header_q.capability_version))
    else $error("version changed while locked");

  a_selector_write_lands: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    (wr_go && wr_sel && w_strb_q[0]) |=>
      value_selector_q == $past(w_data_q[7:0]))
    else $error("selector write lost");

  a_readout_zero_high: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    (ar_take && rd_rdo && value_selector_q > 8'h07) |=>
      rvalid_q && rdata_q == 32'h0000_0000)
    else $error("readout not zero for high selector");

  a_readout_selected: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    (ar_take && rd_rdo && value_selector_q <= 8'h07) |=>
      rdata_q == $past(budget_value_register_q[value_selector_q[2:0]]))
    else $error("readout does not match selected value");

  a_alloc_flag_lock: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    !(wr_go && wr_flg && lock_ok) |=> $stable(system_allocated_flag_q))
    else $error("allocation flag changed without unlocked write");

  a_value_locked: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    !(wr_go && wr_val && budget_value_unlock_q) |=>
      $stable(budget_value_register_q[0]) &&
      $stable(budget_value_register_q[3]) &&
      $stable(budget_value_register_q[7]))
    else $error("value register changed while locked");

  a_reserved_read_zero: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    (ar_take && (rd_sel || rd_flg)) ##1 1'b1 |->
      (rdata_q[31:8] == 24'h000000) &&
      (rdata_q[7:1] == 7'h00 || !$past(rd_flg)))
    else $error("reserved bits not zero");

  a_write_answer: assert property (@(posedge i_ref_clk)
    disable iff (!i_nrst)
    wr_go |=> bvalid_q && bresp_q == ($past(wr_mapped) ?
      pbc_pkg::RESP_OKAY : pbc_pkg::RESP_SLVERR))
    else $error("write answer missing");

  c_unlocked_value_write: cover property (@(posedge i_ref_clk)
    disable iff (!i_nrst) wr_go && wr_val && budget_value_unlock_q);
  c_readout_in_range: cover property (@(posedge i_ref_clk)
    disable iff (!i_nrst) ar_take && rd_rdo && sel_in_range);
  c_readout_out_range: cover property (@(posedge i_ref_clk)
    disable iff (!i_nrst) ar_take && rd_rdo && !sel_in_range);
  c_header_unlocked: cover property (@(posedge i_ref_clk)
    disable iff (!i_nrst) wr_go && wr_hdr && lock_ok);

endmodule : pbc_regs

/* File: tb/pbc_regs_bench.sv */
// self-checking bench for the power budget capability register bank
`timescale 1ns/1ps
module pbc_regs_bench;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, sys_alloc;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;

  pbc_regs i_dut (
    .i_ref_clk(clk), .i_nrst(nrst), .i_awaddr(awaddr), .i_awprot(3'h0),
    .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
    .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
    .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arprot(3'h0), .i_arvalid(arvalid), .o_arready(arready),
    .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
    .o_system_allocated(sys_alloc)
  );

  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic finish_test;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test

  // ceiling well above the few hundred cycles the scenarios need
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      finish_test();
    end
  end

  task automatic check(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // ready is sampled at the falling edge; it cannot move before the rise
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic ta, tw, done;
    logic [1:0] r;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      r = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    check("bresp", {30'h0, r}, {30'h0, er});
  endtask : wr

  task automatic rc(input logic [11:0] a, input logic [31:0] exp,
                    input logic [1:0] er);
    logic ta, done;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    while (!done)
    begin
      @(negedge clk);
      ta = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    check("rdata", d, exp);
    check("rresp", {30'h0, r}, {30'h0, er});
  endtask : rc

  function automatic logic [31:0] val(input int i);
    return 32'(32'h1111_1111 * (i + 1));
  endfunction : val

  task automatic t_reset;
    rc(12'h280, 32'h0, 2'h0);
    rc(12'h284, 32'h0, 2'h0);
    rc(12'h288, 32'h0, 2'h0);
    rc(12'h28C, 32'h0, 2'h0);
    for (int i = 0; i < 8; i++)
      rc(12'h300 + 12'(4 * i), 32'h0, 2'h0);
    check("sys_alloc", {31'h0, sys_alloc}, 32'h0);
  endtask : t_reset

  task automatic t_lockable;
    wr(12'h280, 32'hABC1_0004, 2'h0);
    rc(12'h280, 32'h0, 2'h0);
    wr(12'h28C, 32'h1, 2'h0);
    rc(12'h28C, 32'h0, 2'h0);
    wr(12'h3F0, 32'h2, 2'h0);
    wr(12'h280, 32'hABC1_0004, 2'h0);
    rc(12'h280, 32'hABC1_0004, 2'h0);
    wr(12'h28C, 32'hFFFF_FFFF, 2'h0);
    rc(12'h28C, 32'h1, 2'h0);
    check("sys_alloc", {31'h0, sys_alloc}, 32'h1);
    wr(12'h3F0, 32'h0, 2'h0);
    wr(12'h280, 32'h0, 2'h0);
    wr(12'h28C, 32'h0, 2'h0);
    rc(12'h280, 32'hABC1_0004, 2'h0);
    check("sys_alloc", {31'h0, sys_alloc}, 32'h1);
  endtask : t_lockable

  task automatic t_values;
    wr(12'h300, 32'hDEAD_BEEF, 2'h0);
    rc(12'h288, 32'h0, 2'h0);
    wr(12'h3F0, 32'h1, 2'h0);
    rc(12'h3F0, 32'h1, 2'h0);
    for (int i = 0; i < 8; i++)
      wr(12'h300 + 12'(4 * i), val(i), 2'h0);
    for (int i = 0; i < 8; i++)
    begin
      wr(12'h284, 32'(i), 2'h0);
      rc(12'h288, val(i), 2'h0);
    end
    // low two byte lanes only; the upper half must keep its old value
    @(posedge clk);
    wstrb <= 4'h3;
    wr(12'h304, 32'hAAAA_5555, 2'h0);
    wstrb <= 4'hF;
    rc(12'h304, 32'h2222_5555, 2'h0);
    wr(12'h3F0, 32'h0, 2'h0);
    wr(12'h30C, 32'h0, 2'h0);
    rc(12'h30C, val(3), 2'h0);
  endtask : t_values

  task automatic t_select;
    wr(12'h284, 32'hFFFF_FF05, 2'h0);
    rc(12'h284, 32'h0000_0005, 2'h0);
    rc(12'h288, val(5), 2'h0);
    wr(12'h284, 32'h8, 2'h0);
    rc(12'h288, 32'h0, 2'h0);
    wr(12'h284, 32'hFF, 2'h0);
    rc(12'h288, 32'h0, 2'h0);
    wr(12'h284, 32'h2, 2'h0);
    wr(12'h288, 32'h1234_5678, 2'h0);
    rc(12'h288, val(2), 2'h0);
    wr(12'h290, 32'h1, 2'h2);
    rc(12'h290, 32'h0, 2'h2);
  endtask : t_select

  // a second reset in mid-run must clear everything, flag output included
  task automatic t_rereset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    check("sys_alloc", {31'h0, sys_alloc}, 32'h0);
    check("readies", {29'h0, awready, wready, arready}, 32'h7);
    check("valids", {30'h0, bvalid, rvalid}, 32'h0);
    rc(12'h280, 32'h0, 2'h0);
    rc(12'h304, 32'h0, 2'h0);
  endtask : t_rereset

  initial
  begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_reset();
    t_lockable();
    t_values();
    t_select();
    t_rereset();
    finish_test();
  end
endmodule : pbc_regs_bench
